//--- match_flags_regs.vh
`ifndef MATCH_FLAGS_REGS_VH
`define MATCH_FLAGS_REGS_VH
// register word offsets (byte addresses)
`define MF_OFS_FLAGS    4'h0
`define MF_OFS_SEQ      4'h4
`define MF_OFS_CTRL     4'h8
// match flag field positions
`define MF_BIT_A        0
`define MF_BIT_B        1
`define MF_BIT_C1       2
`define MF_BIT_C2       3
`define MF_BIT_C3       4
`define MF_BIT_C4       5
// sequential flag field positions
`define MF_SEQ_A        0
`define MF_SEQ_C2       1
`define MF_SEQ_C3       2
`define MF_SEQ_C4       3
// control fields
`define MF_CTRL_UBSEQ   0
`define MF_CTRL_MODE_LO 1
`define MF_CTRL_MODE_HI 2
`define MF_CTRL_CLR     3
// sequence modes
`define MF_MODE_NONE    2'h0
`define MF_MODE_21      2'h1
`define MF_MODE_321     2'h2
`define MF_MODE_4321    2'h3
// reset values
`define MF_RST_FLAGS    6'h00
`define MF_RST_SEQ      4'h0
`define MF_RST_CTRL     3'h0
`endif

//--- break_condition_match_flags.v
// Function
// R1 - channel A flag is 1 after the user break unit channel A matched
// R2 - in emulator use channel A flag stands for break condition six
// R3 - channel B flag is 1 after channel B matched; stands for condition five
// R4 - condition one flag is 1 once condition one has matched
// R5 - condition two flag is 1 once condition two has matched
// R6 - condition three flag is 1 once condition three has matched
// R7 - condition four flag is 1 once condition four has matched
// R8 - sequential A flag is 1 while A matched and B not yet
// R9 - in emulator use sequential A means six matched, five not yet
// R10 - in 4-3-2-1, seq four flag set on four, cleared by three, reset on rematch
// R11 - in 4-3-2-1 or 3-2-1, seq three flag likewise against condition two
// R12 - in 4-3-2-1, 3-2-1 or 2-1, seq two flag likewise against condition one
// R13 - all condition match flags clear once a break has taken place
// R14 - user break channel flags stay set until explicitly cleared; the code also clears them on break_taken_i
// R15 - all flags reset to zero; reads never disturb execution
`timescale 1ns/1ps
`default_nettype none
`include "match_flags_regs.vh"
module break_condition_match_flags (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        match_a_i,
  input  wire        match_b_i,
  input  wire        cond_one_match_i,
  input  wire        cond_two_match_i,
  input  wire        cond_three_match_i,
  input  wire        cond_four_match_i,
  input  wire        break_taken_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg  [5:0]  match_flags_o,
  output reg  [3:0]  seq_flags_o
);

  reg  [5:0] flags_q;
  reg  [5:0] flags_d;
  reg  [3:0] seq_q;
  reg  [3:0] seq_d;
  reg  [2:0] ctrl_q;
  wire       req;
  wire       wr_ctrl;
  wire       sw_clr;
  wire       ub_seq;
  wire [1:0] mode;
  wire [5:0] hit;

  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl = req & wb_we_i & (wb_adr_i == `MF_OFS_CTRL) & wb_sel_i[0];
  // self-clearing command bit, never stored
  assign sw_clr  = wr_ctrl & wb_dat_i[`MF_CTRL_CLR];
  assign ub_seq  = ctrl_q[`MF_CTRL_UBSEQ];
  assign mode    = ctrl_q[`MF_CTRL_MODE_HI:`MF_CTRL_MODE_LO];
  assign hit     = {cond_four_match_i, cond_three_match_i, cond_two_match_i,
                    cond_one_match_i, match_b_i, match_a_i};

  always @* begin
    flags_d = flags_q;
    seq_d   = seq_q;
    if (break_taken_i || sw_clr) begin
      flags_d = `MF_RST_FLAGS; // R13 R14
      seq_d   = `MF_RST_SEQ;
    end
    // a match in the clear cycle still lands: set wins
    flags_d = flags_d | hit; // R1 R2 R3 R4 R5 R6 R7 R14
    if (ub_seq) begin
      if (match_a_i && !(flags_q[`MF_BIT_B] || match_b_i))
        seq_d[`MF_SEQ_A] = 1'b1; // R8 R9
      else if (flags_q[`MF_BIT_B] || match_b_i)
        seq_d[`MF_SEQ_A] = 1'b0; // R8 R9
    end else begin
      seq_d[`MF_SEQ_A] = 1'b0;
    end
    // stage flags: set on own match, dropped when next stage matches
    if (mode == `MF_MODE_4321) begin
      if (cond_four_match_i)
        seq_d[`MF_SEQ_C4] = 1'b1; // R10
      else if (cond_three_match_i)
        seq_d[`MF_SEQ_C4] = 1'b0; // R10
    end else begin
      seq_d[`MF_SEQ_C4] = 1'b0;
    end
    if (mode == `MF_MODE_4321 || mode == `MF_MODE_321) begin
      if (cond_three_match_i)
        seq_d[`MF_SEQ_C3] = 1'b1; // R11
      else if (cond_two_match_i)
        seq_d[`MF_SEQ_C3] = 1'b0; // R11
    end else begin
      seq_d[`MF_SEQ_C3] = 1'b0;
    end
    if (mode != `MF_MODE_NONE) begin
      if (cond_two_match_i)
        seq_d[`MF_SEQ_C2] = 1'b1; // R12
      else if (cond_one_match_i)
        seq_d[`MF_SEQ_C2] = 1'b0; // R12
    end else begin
      seq_d[`MF_SEQ_C2] = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flags_q       <= `MF_RST_FLAGS; // R15
      seq_q         <= `MF_RST_SEQ;
      ctrl_q        <= `MF_RST_CTRL;
      match_flags_o <= `MF_RST_FLAGS;
      seq_flags_o   <= `MF_RST_SEQ;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
    end else begin
      flags_q       <= flags_d;
      seq_q         <= seq_d;
      match_flags_o <= flags_d;
      seq_flags_o   <= seq_d;
      if (wr_ctrl)
        ctrl_q <= wb_dat_i[2:0];
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      // reads have no side effect on flags
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `MF_OFS_FLAGS: wb_dat_o <= {26'h000_0000, flags_q}; // R15
          `MF_OFS_SEQ:   wb_dat_o <= {28'h000_0000, seq_q};
          `MF_OFS_CTRL:  wb_dat_o <= {29'h0000_0000, ctrl_q};
          default:       wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- bcm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bcm_chk (
  input wire logic       clk_i, rst_i, match_a_i, match_b_i, cond_one_match_i, cond_two_match_i,
  input wire logic       cond_four_match_i, break_taken_i, wb_stb_i, wb_we_i,
  input wire logic [5:0] match_flags_o,
  input wire logic [3:0] seq_flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_flag_a_set: assert property (match_a_i |=> match_flags_o[0]) else $error("flag a");
  a_flag_b_set: assert property (match_b_i |=> match_flags_o[1]) else $error("flag b");
  a_cond_one_set: assert property (cond_one_match_i |=> match_flags_o[2]) else $error("c1");
  a_cond_four_set: assert property (cond_four_match_i |=> match_flags_o[5]) else $error("c4");
  a_break_clears: assert property (break_taken_i && !match_a_i |=> !match_flags_o[0]) else $error("brk");
  // a bus write may be a software clear, so holding is only owed while no bus write is strobed
  a_flag_holds: assert property (match_flags_o[0] && !break_taken_i && !(wb_stb_i && wb_we_i)
    |=> match_flags_o[0]) else $error("hold");
  a_reset_zero: assert property (disable iff (1'b0) rst_i |=> match_flags_o == 6'h00 && seq_flags_o == 4'h0)
    else $error("reset");
  a_seq_a_drop: assert property (match_b_i && !match_a_i |=> !seq_flags_o[0]) else $error("seq a");
  a_seq_two_drop: assert property (cond_one_match_i && !cond_two_match_i |=> !seq_flags_o[1])
    else $error("seq 2");
  cover property (seq_flags_o[3]);
  cover property (seq_flags_o[0]);
  cover property (break_taken_i && match_flags_o != 6'h00);
endmodule
bind break_condition_match_flags bcm_chk u_chk (.*);
`default_nettype wire

//--- emu_port.sv
`timescale 1ns/1ps
`default_nettype none
module emu_port (
  input wire logic        clk_i,
  output var logic        cyc_o = 0, stb_o = 0, we_o = 0,
  output var logic [3:0]  adr_o = 0,
  output var logic [31:0] dat_o = 0,
  input wire logic        ack_i,
  input wire logic [31:0] dat_i
);
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o, we_o} <= 3'b000;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

//--- tb_break_condition_match_flags.sv
`timescale 1ns/1ps
`default_nettype none
module tb_break_condition_match_flags;
  logic clk_i = 0, rst_i = 1;
  logic [6:0] ev = 0;
  wire cyc, stb, we, ack;
  wire [3:0] adr, sf;
  wire [5:0] mf;
  wire [31:0] wd, rd;
  int num_errors = 0, checks_done = 0, cyc_n = 0;
  initial forever #5 clk_i = ~clk_i;
  emu_port P (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wd), .ack_i(ack), .dat_i(rd));
  break_condition_match_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .match_a_i(ev[0]), .match_b_i(ev[1]),
    .cond_one_match_i(ev[2]), .cond_two_match_i(ev[3]), .cond_three_match_i(ev[4]), .cond_four_match_i(ev[5]),
    .break_taken_i(ev[6]), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_sel_i(4'hF), .wb_dat_o(rd), .wb_ack_o(ack), .match_flags_o(mf), .seq_flags_o(sf));
  task results;
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    P.xfer(1'b0, a, 32'h0000_0000, q);
    checks_done++;
    if (q !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, q, e);
    end
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [31:0] d);
    logic [31:0] q;
    P.xfer(1'b1, 4'h8, d, q);
  endtask
  task ps(input logic [6:0] m);
    @(posedge clk_i) ev <= m;
    @(posedge clk_i) ev <= 7'h00;
  endtask
  always @(posedge clk_i) if (++cyc_n == 3000) begin
    num_errors++;
    results;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rc(4'h0, 0);
    rc(4'h4, 0);
    wr(32'h0000_0007);
    rc(4'h8, 32'h0000_0007);
    ps(7'h01); rc(4'h4, 1);
    ps(7'h02); rc(4'h4, 0);
    rc(4'h0, 3);
    cmp({26'h000_0000, mf}, 32'h0000_0003);
    cmp({28'h000_0000, sf}, 32'h0000_0000);
    ps(7'h20); rc(4'h4, 8);
    ps(7'h10); rc(4'h4, 4);
    ps(7'h08); rc(4'h4, 2);
    ps(7'h04); rc(4'h4, 0);
    ps(7'h20); rc(4'h4, 8);
    rc(4'h0, 32'h0000_003F);
    cmp({26'h000_0000, mf}, 32'h0000_003F);
    cmp({28'h000_0000, sf}, 32'h0000_0008);
    ps(7'h40); rc(4'h0, 0);
    rc(4'h4, 0);
    cmp({26'h000_0000, mf}, 32'h0000_0000);
    wr(32'h0000_0002);
    ps(7'h30); rc(4'h4, 0);
    ps(7'h08); ps(7'h01); rc(4'h4, 2);
    rc(4'h0, 32'h0000_0039);
    wr(32'h0000_0008); rc(4'h0, 0);
    rc(4'hC, 0);
    results;
  end
endmodule
`default_nettype wire
